//--- logic/adcc_top.sv
// Converter control top: AXI4-Lite registers, flags, formatting, sequencing
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
module adcc_top #(
  parameter int ADDR_W = adcc_pkg::ADDR_W
) (
  input  wire logic              aclk,                 // 250 MHz bus clock
  input  wire logic              aresetn,              // Sync reset, active low
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,         // Write address
  input  wire logic              s_axi_awvalid,        // Write address valid
  output logic                   s_axi_awready,        // Write address ready
  input  wire logic [31:0]       s_axi_wdata,          // Write data
  input  wire logic [3:0]        s_axi_wstrb,          // Write strobes
  input  wire logic              s_axi_wvalid,         // Write data valid
  output logic                   s_axi_wready,         // Write data ready
  output logic [1:0]             s_axi_bresp,          // Write response
  output logic                   s_axi_bvalid,         // Write response valid
  input  wire logic              s_axi_bready,         // Write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,         // Read address
  input  wire logic              s_axi_arvalid,        // Read address valid
  output logic                   s_axi_arready,        // Read address ready
  output logic [31:0]            s_axi_rdata,          // Read data
  output logic [1:0]             s_axi_rresp,          // Read response
  output logic                   s_axi_rvalid,         // Read data valid
  input  wire logic              s_axi_rready,         // Read data ready
  input  wire logic              crystal_clock,        // Crystal clock pin
  input  wire logic              stop_mode,            // Processor in stop mode
  input  wire logic              cmp_above,            // Comparator: input above DAC
  output logic [9:0]             dac_code,             // Trial code to the DAC
  output logic [4:0]             channel_select,       // Analog mux code
  output logic                   converter_power_down, // Analog power off
  output logic                   conversion_irq        // Interrupt request, high
);
  adcc_conv_if cv ();

  logic              aw_full_reg;
  logic              w_full_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0]        wdata_reg;
  logic              wlane_reg;
  logic              cmp_meta;
  logic              cmp_sync;
  logic              flag_reg;
  logic              ien_reg;
  logic              cont_reg;
  logic [4:0]        chan_reg;
  logic [2:0]        div_reg;
  logic              src_reg;
  logic [1:0]        mode_reg;
  logic [7:0]        high_reg;
  logic [7:0]        low_reg;
  logic              lock_reg;
  logic              irq_reg;
  logic              stop_prev_reg;
  logic              resume_reg;
  logic              pd_reg;

  // Register index from a byte address
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
    return addr[9:2];
  endfunction : reg_index

  // Index maps to one of the four registers
  function automatic logic is_mapped(input logic [7:0] idx);
    return (idx == adcc_pkg::IDX_SC) || (idx == adcc_pkg::IDX_HIGH) ||
           (idx == adcc_pkg::IDX_LOW) || (idx == adcc_pkg::IDX_CLK);
  endfunction : is_mapped

  // Result to {high, low} byte pair by justification mode
  function automatic logic [15:0] fmt(input logic [1:0] mode, input logic [9:0] r);
    unique case (mode)
      adcc_pkg::MODE_TRUNC:  return {8'h00, r[9:2]};
      adcc_pkg::MODE_RIGHT:  return {6'h00, r[9:8], r[7:0]};
      adcc_pkg::MODE_LEFT:   return {r[9:2], r[1:0], 6'h00};
      adcc_pkg::MODE_SIGNED: return {~r[9], r[8:2], r[1:0], 6'h00};
    endcase
  endfunction : fmt

  // Write path decode
  wire       aw_hs     = s_axi_awvalid & s_axi_awready;
  wire       w_hs      = s_axi_wvalid & s_axi_wready;
  wire       wr_do     = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  wire [7:0] wr_idx    = reg_index(awaddr_reg);
  wire       wr_en     = wr_do & wlane_reg;
  wire       wr_sc     = wr_en & (wr_idx == adcc_pkg::IDX_SC);
  wire       wr_clk    = wr_en & (wr_idx == adcc_pkg::IDX_CLK);

  // Read path decode; side effects happen when the address is taken
  wire       ar_hs     = s_axi_arvalid & s_axi_arready;
  wire [7:0] rd_idx    = reg_index(s_axi_araddr);
  wire       rd_high   = ar_hs & (rd_idx == adcc_pkg::IDX_HIGH);
  wire       rd_low    = ar_hs & (rd_idx == adcc_pkg::IDX_LOW);
  wire       interlock = (mode_reg != adcc_pkg::MODE_TRUNC);

  // Read value; flag masked while interrupts enabled
  wire       flag_rd   = flag_reg & ~ien_reg;
  wire [7:0] sc_rd     = {flag_rd, ien_reg, cont_reg, chan_reg};
  wire [7:0] clk_rd    = {div_reg, src_reg, mode_reg, 2'b00};
  wire [7:0] rd_byte   = (rd_idx == adcc_pkg::IDX_SC)   ? sc_rd    :
                         (rd_idx == adcc_pkg::IDX_HIGH) ? high_reg :
                         (rd_idx == adcc_pkg::IDX_LOW)  ? low_reg  :
                         (rd_idx == adcc_pkg::IDX_CLK)  ? clk_rd   : 8'h00;

  // Newly written settings decide the restarted conversion
  wire [4:0] chan_new  = wr_sc ? wdata_reg[4:0] : chan_reg;
  wire       cont_new  = wr_sc ? wdata_reg[adcc_pkg::SC_CONT] : cont_reg;
  wire       chan_on   = (chan_new != adcc_pkg::CHAN_OFF);
  wire       stop_exit = stop_prev_reg & ~stop_mode;
  wire       stop_ent  = stop_mode & ~stop_prev_reg;

  // Result storage allowed unless interlocked and high byte read with low byte pending
  wire       store_ok  = ~interlock | (~lock_reg & ~rd_high);
  wire [15:0] fmt_res  = fmt(mode_reg, cv.result);

  // Conversion start and abort sources
  assign cv.start = ~stop_mode & chan_on &
                    (wr_sc |
                     (stop_exit & (resume_reg | cont_new)) |
                     (cv.done & cont_new));
  assign cv.abort = wr_sc | stop_mode;
  assign cv.cmp_above = cmp_sync;

  adcc_clkdiv u_clkdiv (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .crystal_clock (crystal_clock),
    .src_bus       (src_reg),
    .prescale      (div_reg),
    .tick          (cv.tick)
  );

  adcc_sar u_sar (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cv      (cv.core)
  );

  // Comparator is asynchronous to the bus clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      cmp_meta <= cmp_above;
      cmp_sync <= cmp_meta;
    end
  end

  // AXI write channel capture; address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      awaddr_reg    <= '0;
      wdata_reg     <= 8'h00;
      wlane_reg     <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= adcc_pkg::RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_full_reg   <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_hs) begin
        w_full_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata[7:0];
        wlane_reg    <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(wr_idx) ? adcc_pkg::RESP_OKAY : adcc_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI read channel; one outstanding read, answer next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= adcc_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_byte};
      s_axi_rresp   <= is_mapped(rd_idx) ? adcc_pkg::RESP_OKAY : adcc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ien_reg  <= 1'b0;
      cont_reg <= 1'b0;
      chan_reg <= adcc_pkg::CHAN_RESET;
      div_reg  <= adcc_pkg::DIV_RESET;
      src_reg  <= adcc_pkg::SRC_RESET;
      mode_reg <= adcc_pkg::MODE_RIGHT;
    end else begin
      if (wr_sc) begin
        ien_reg  <= wdata_reg[adcc_pkg::SC_IEN];
        cont_reg <= wdata_reg[adcc_pkg::SC_CONT];
        chan_reg <= wdata_reg[4:0];
      end
      if (wr_clk) begin
        div_reg  <= wdata_reg[adcc_pkg::CK_DIV_LSB +: 3];
        src_reg  <= wdata_reg[adcc_pkg::CK_SRC];
        mode_reg <= wdata_reg[adcc_pkg::CK_MODE_LSB +: 2];
      end
    end
  end

  // Completion flag and interrupt; a new completion wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= 1'b0;
      irq_reg  <= 1'b0;
    end else begin
      if (cv.done) begin
        flag_reg <= 1'b1;
      end else if (wr_sc || wr_clk || rd_low) begin
        flag_reg <= 1'b0;
      end
      if (cv.done && ien_reg) begin
        irq_reg <= 1'b1;
      end else if (wr_sc || rd_high || rd_low) begin
        irq_reg <= 1'b0;
      end
    end
  end

  // Result pair and high/low interlock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_reg <= 8'h00;
      low_reg  <= 8'h00;
      lock_reg <= 1'b0;
    end else begin
      if (cv.done && store_ok) begin
        high_reg <= fmt_res[15:8];
        low_reg  <= fmt_res[7:0];
      end
      if (rd_low) begin
        lock_reg <= 1'b0;
      end else if (rd_high && interlock) begin
        lock_reg <= 1'b1;
      end
    end
  end

  // Stop tracking, resume after stop, pin-side outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_prev_reg <= 1'b0;
      resume_reg    <= 1'b0;
      pd_reg        <= 1'b1;
    end else begin
      stop_prev_reg <= stop_mode;
      if (stop_ent) begin
        resume_reg <= cv.busy;
      end else if (stop_exit || wr_sc) begin
        resume_reg <= 1'b0;
      end
      pd_reg <= stop_mode | (chan_reg == adcc_pkg::CHAN_OFF);
    end
  end

  // Wait mode needs no logic: conversions simply continue
  assign dac_code             = cv.dac_code;
  assign channel_select       = chan_reg;
  assign converter_power_down = pd_reg;
  assign conversion_irq       = irq_reg;
endmodule : adcc_top

//--- logic/adcc_pkg.sv
// Shared constants for the converter control block
// Contract
// - Continuous mode converts repeatedly, overwriting the result pair whether read or not; code drops new results after an interlocked high read.
// - Continuous bit set keeps converting; clear means one conversion per start.
// - Flag sets at every conversion end; cleared by control writes or low-byte read.
// - With interrupt enabled the flag reads 0 and an interrupt request is raised.
// - Pending interrupt request drops on result read or status/control write.
// - Status/control write aborts any conversion and starts anew with new settings.
// - Reset clears flag, interrupt enable and continuous bit.
// - Two justification bits in the clock control register select four result formats.
// - Left format: eight top bits in high byte, two low bits atop low byte.
// - Interlocked formats drop new results until the low byte follows a high read.
// - Right format: two top bits low in high byte, eight low bits in low byte.
// - Signed left format is left format with result bit 9 inverted.
// - In wait mode conversions and their interrupt carry on normally.
// - Stop mode aborts conversion and idles; conversions resume after stop ends.
// - Decode 5-bit channel: 0-5 pins, 6 bandgap, 29 high, 30 low, 31 off.
// - Reserved channel codes 7 to 28 give undefined results.
// - A conversion takes 16 to 17 converter clock cycles including start alignment.
// - Justification codes 00 trunc, 01 right, 10 left, 11 signed; reset right.
// - Converter clock is bus or crystal clock divided by 1,2,4,8,16; reset crystal.
// - High-byte read freezes the low byte until the low byte is read; code freezes only in interlocked formats, not trunc.
package adcc_pkg;
  localparam int          RES_W       = 10;
  localparam int          ADDR_W      = 12;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_SC      = 8'h3C;
  localparam logic [7:0]  IDX_HIGH    = 8'h3D;
  localparam logic [7:0]  IDX_LOW     = 8'h3E;
  localparam logic [7:0]  IDX_CLK     = 8'h3F;
  // Status/control fields
  localparam int          SC_FLAG     = 7;
  localparam int          SC_IEN      = 6;
  localparam int          SC_CONT     = 5;
  localparam logic [4:0]  CHAN_RESET  = 5'h1F;
  localparam logic [4:0]  CHAN_OFF    = 5'h1F;
  localparam logic [4:0]  CHAN_BGAP   = 5'h06;
  localparam logic [4:0]  CHAN_REFERENCE_HIGH_INPUT  = 5'h1D;
  localparam logic [4:0]  CHAN_REFERENCE_LOW_INPUT  = 5'h1E;
  // Clock control fields
  localparam int          CK_DIV_LSB  = 5;
  localparam int          CK_SRC      = 4;
  localparam int          CK_MODE_LSB = 2;
  localparam logic [2:0]  DIV_RESET   = 3'h0;
  localparam logic        SRC_RESET   = 1'b0;
  localparam logic [1:0]  MODE_TRUNC  = 2'h0;
  localparam logic [1:0]  MODE_RIGHT  = 2'h1;
  localparam logic [1:0]  MODE_LEFT   = 2'h2;
  localparam logic [1:0]  MODE_SIGNED = 2'h3;
  // Index of the last conversion step, counted in converter clocks after the aligning tick
  localparam logic [3:0]  CONV_LAST   = 4'hF;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : adcc_pkg

//--- logic/adcc_conv_if.sv
// Control-to-converter-core signal bundle
`timescale 1ns/1ns
interface adcc_conv_if;
  logic       start;
  logic       abort;
  logic       tick;
  logic       cmp_above;
  logic       done;
  logic       busy;
  logic [9:0] result;
  logic [9:0] dac_code;
  modport ctrl (output start, abort, tick, cmp_above, input done, busy, result, dac_code);
  modport core (input start, abort, tick, cmp_above, output done, busy, result, dac_code);
endinterface : adcc_conv_if

//--- logic/adcc_clkdiv.sv
// Converter clock enable: source select and power-of-two prescaler
`timescale 1ns/1ns
module adcc_clkdiv (
  input  wire logic       aclk,          // Bus clock
  input  wire logic       aresetn,       // Sync reset, active low
  input  wire logic       crystal_clock, // Asynchronous crystal clock pin
  input  wire logic       src_bus,       // 1 bus clock, 0 crystal
  input  wire logic [2:0] prescale,      // Divide select
  output logic            tick           // One-cycle converter clock enable
);
  logic       xtal_meta;
  logic       xtal_sync;
  logic       xtal_prev;
  logic [3:0] cnt_reg;
  logic       src_pulse;
  logic [3:0] limit;

  // Divide ratio minus one; top bit set means sixteen
  function automatic logic [3:0] div_limit(input logic [2:0] sel);
    if (sel[2]) begin
      return 4'hF;
    end
    return 4'((5'h01 << sel) - 5'h01);
  endfunction : div_limit

  assign limit     = div_limit(prescale);
  assign src_pulse = src_bus ? 1'b1 : (xtal_sync & ~xtal_prev);

  // Crystal edge through two flops; edge seen only after the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xtal_meta <= 1'b0;
      xtal_sync <= 1'b0;
      xtal_prev <= 1'b0;
    end else begin
      xtal_meta <= crystal_clock;
      xtal_sync <= xtal_meta;
      xtal_prev <= xtal_sync;
    end
  end

  // Free counter; masked compare avoids a reload when the ratio changes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 4'h0;
      tick    <= 1'b0;
    end else begin
      tick <= src_pulse && ((cnt_reg & limit) == limit);
      if (src_pulse) begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule : adcc_clkdiv

//--- logic/adcc_sar.sv
// Successive approximation sequencer driven by converter clock ticks
`timescale 1ns/1ns
module adcc_sar (
  input  wire logic aclk,    // Bus clock
  input  wire logic aresetn, // Sync reset, active low
  adcc_conv_if.core cv       // Control bundle
);
  typedef enum logic [1:0] {S_IDLE, S_ALIGN, S_CONV} adcc_sar_state_t;
  adcc_sar_state_t state_reg;
  logic [3:0]      step_reg;
  logic [9:0]      trial_reg;
  logic [3:0]      bit_idx;

  assign bit_idx     = 4'd9 - step_reg;
  assign cv.busy     = (state_reg != S_IDLE);
  assign cv.dac_code = trial_reg;
  assign cv.result   = trial_reg;

  // Start waits for a tick, then sixteen ticks: 16 to 17 clocks in all
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= S_IDLE;
      step_reg  <= 4'h0;
      trial_reg <= 10'h000;
      cv.done   <= 1'b0;
    end else begin
      cv.done <= 1'b0;
      if (cv.start) begin
        state_reg <= S_ALIGN;
      end else if (cv.abort) begin
        state_reg <= S_IDLE;
      end else if (cv.tick) begin
        unique case (state_reg)
          S_IDLE: begin
          end
          S_ALIGN: begin
            state_reg <= S_CONV;
            step_reg  <= 4'h0;
            trial_reg <= 10'h200;
          end
          S_CONV: begin
            step_reg <= step_reg + 4'h1;
            if (step_reg < 4'd10) begin
              trial_reg[bit_idx] <= cv.cmp_above;
              if (step_reg != 4'd9) begin
                trial_reg[bit_idx - 4'd1] <= 1'b1;
              end
            end
            if (step_reg == adcc_pkg::CONV_LAST) begin
              cv.done   <= 1'b1;
              state_reg <= S_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule : adcc_sar

//--- sim/adcc_sva.sv
// Port-level assertions for the converter control top
`timescale 1ns/1ns
module adcc_sva #(
  parameter int ADDR_W = 12
) (
  input logic              aclk,                 // Bus clock
  input logic              aresetn,              // Sync reset, low
  input logic              s_axi_awvalid,        // Write address valid
  input logic              s_axi_awready,        // Write address ready
  input logic              s_axi_wvalid,         // Write data valid
  input logic              s_axi_wready,         // Write data ready
  input logic [1:0]        s_axi_bresp,          // Write response
  input logic              s_axi_bvalid,         // Write response valid
  input logic              s_axi_bready,         // Write response ready
  input logic [ADDR_W-1:0] s_axi_araddr,         // Read address
  input logic              s_axi_arvalid,        // Read address valid
  input logic              s_axi_arready,        // Read address ready
  input logic [31:0]       s_axi_rdata,          // Read data
  input logic [1:0]        s_axi_rresp,          // Read response
  input logic              s_axi_rvalid,         // Read data valid
  input logic              s_axi_rready,         // Read data ready
  input logic [4:0]        channel_select,       // Mux code
  input logic              converter_power_down, // Analog off
  input logic              conversion_irq        // Interrupt request
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Read handshake and the register it targets
  wire       ar_go  = s_axi_arvalid && s_axi_arready;
  wire [7:0] ar_idx = s_axi_araddr[9:2];
  a_reset_state: assert property (disable iff (1'b0) !aresetn |=>
    channel_select == adcc_pkg::CHAN_RESET && converter_power_down && !conversion_irq)
    else $error("reset state wrong");
  a_read_turn: assert property (ar_go |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_write_turn: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_unmapped_err: assert property (ar_go && ar_idx < adcc_pkg::IDX_SC
    |=> s_axi_rresp == adcc_pkg::RESP_SLVERR && s_axi_rdata == '0) else $error("unmapped read");
  a_flag_masked: assert property (ar_go && ar_idx == adcc_pkg::IDX_SC
    |=> !(s_axi_rdata[7] && s_axi_rdata[6])) else $error("flag seen with irq enabled");
  a_irq_clear: assert property (ar_go && conversion_irq &&
    (ar_idx == adcc_pkg::IDX_HIGH || ar_idx == adcc_pkg::IDX_LOW) |=> !conversion_irq)
    else $error("irq kept after result read");
  a_off_power: assert property (channel_select == adcc_pkg::CHAN_OFF &&
    $past(channel_select) == adcc_pkg::CHAN_OFF |-> converter_power_down) else $error("not off");
endmodule : adcc_sva

bind adcc_top adcc_sva #(.ADDR_W(ADDR_W)) sva_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .channel_select, .converter_power_down, .conversion_irq);

//--- sim/tb.sv
// Self-checking bench for the converter control top
`timescale 1ns/1ns
module tb;
  logic        aclk = 0, aresetn = 0, crystal_clock = 0, stop_mode = 0, cmp_above = 0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, converter_power_down, conversion_irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [9:0]  dac_code, target = '0;
  logic [4:0]  channel_select;
  logic [7:0]  rv;
  logic [15:0] e16;
  int          mismatches = 0, check_count = 0;

  adcc_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .crystal_clock, .stop_mode, .cmp_above, .dac_code, .channel_select,
    .converter_power_down, .conversion_irq);

  // 250 MHz bus clock
  initial forever #2 aclk = ~aclk;
  // Ideal comparator standing in for the analog input
  always @(posedge aclk) cmp_above <= (target >= dac_code);
  // Crystal clock at half the bus clock rate
  always @(posedge aclk) crystal_clock <= ~crystal_clock;

  // Write one register; address and data released each on its own handshake
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    s_axi_awaddr  <= {2'h0, idx, 2'h0};
    s_axi_wdata   <= {24'h00_0000, v};
    s_axi_awvalid <= 1;
    s_axi_wvalid  <= 1;
    s_axi_bready  <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) aw_done = 1;
      if (s_axi_wready) w_done = 1;
      s_axi_awvalid <= !aw_done;
      s_axi_wvalid  <= !w_done;
    end while (!(aw_done && w_done) && !s_axi_bvalid);
    while (!s_axi_bvalid) @(posedge aclk);
    rr = s_axi_bresp;
    s_axi_bready <= 0;
  endtask : wr

  // Read one register into rv and rr
  task automatic rd(input logic [7:0] idx);
    @(posedge aclk);
    s_axi_araddr  <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1;
    s_axi_rready  <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rv = s_axi_rdata[7:0];
    rr = s_axi_rresp;
    s_axi_rready <= 0;
  endtask : rd

  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
    rd(idx);
    chk(nm, {2'h0, e}, {2'h0, rv});
  endtask : rchk

  // Poll the status register until a conversion completes
  task automatic wait_flag;
    do rd(adcc_pkg::IDX_SC); while (rv[7] !== 1'b1);
  endtask : wait_flag

  // Expected high/low byte pair for one justification mode
  function automatic logic [15:0] fmt(input logic [1:0] m, input logic [9:0] x);
    case (m)
      adcc_pkg::MODE_TRUNC: return {8'h00, x[9:2]};
      adcc_pkg::MODE_RIGHT: return {6'h00, x};
      adcc_pkg::MODE_LEFT:  return {x, 6'h00};
      default:              return {~x[9], x[8:0], 6'h00};
    endcase
  endfunction : fmt

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // Watchdog: about fifteen conversions of 272 cycles (544 on the crystal clock) plus polling fit well inside
  initial begin
    #160000;
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rchk("status reset", adcc_pkg::IDX_SC, 8'h1F);
    rchk("clock reset", adcc_pkg::IDX_CLK, 8'h04);
    rd(8'h04);
    chk("unmapped resp", {8'h00, adcc_pkg::RESP_SLVERR}, {8'h00, rr});
    wr(8'h04, 8'h00);
    chk("unmapped wresp", {8'h00, adcc_pkg::RESP_SLVERR}, {8'h00, rr});
    chk("power reset", 10'h001, {9'h000, converter_power_down});
    $display("test reset done");
    // Crystal and bus clock /16, every justification mode
    for (int m = 0; m < 4; m++) begin
      wr(adcc_pkg::IDX_CLK, {3'h4, m[0], m[1:0], 2'h0});
      target <= 10'h2A5 ^ 10'(m);
      e16 = fmt(m[1:0], 10'h2A5 ^ 10'(m));
      wr(adcc_pkg::IDX_SC, 8'h00);
      wait_flag();
      rchk("high", adcc_pkg::IDX_HIGH, e16[15:8]);
      rchk("low", adcc_pkg::IDX_LOW, e16[7:0]);
      rchk("flag after low", adcc_pkg::IDX_SC, 8'h00);
    end
    $display("test formats done");
    // High read locks; a later result is dropped
    wr(adcc_pkg::IDX_CLK, 8'h94);
    target <= 10'h155;
    wr(adcc_pkg::IDX_SC, 8'h00);
    wait_flag();
    rchk("locked high", adcc_pkg::IDX_HIGH, 8'h01);
    target <= 10'h0AA;
    wr(adcc_pkg::IDX_SC, 8'h00);
    wait_flag();
    wr(adcc_pkg::IDX_CLK, 8'h94);
    rchk("flag after clock write", adcc_pkg::IDX_SC, 8'h00);
    rchk("locked low", adcc_pkg::IDX_LOW, 8'h55);
    $display("test interlock done");
    // Interrupt mode: flag hidden, request dropped by result read
    target <= 10'h3FF;
    wr(adcc_pkg::IDX_SC, 8'h40);
    do @(posedge aclk); while (conversion_irq !== 1'b1);
    rchk("masked flag", adcc_pkg::IDX_SC, 8'h40);
    rchk("irq high byte", adcc_pkg::IDX_HIGH, 8'h03);
    chk("irq cleared", 10'h000, {9'h000, conversion_irq});
    rchk("irq low byte", adcc_pkg::IDX_LOW, 8'hFF);
    $display("test interrupt done");
    // Continuous mode keeps overwriting with no further writes
    target <= 10'h0F0;
    wr(adcc_pkg::IDX_SC, 8'h20);
    wait_flag();
    rchk("cont first", adcc_pkg::IDX_LOW, 8'hF0);
    target <= 10'h30F;
    wait_flag();
    rd(adcc_pkg::IDX_LOW);
    wait_flag();
    rchk("cont high", adcc_pkg::IDX_HIGH, 8'h03);
    rchk("cont low", adcc_pkg::IDX_LOW, 8'h0F);
    // Single mode goes idle after one result
    wr(adcc_pkg::IDX_SC, 8'h00);
    wait_flag();
    rd(adcc_pkg::IDX_LOW);
    repeat (600) @(posedge aclk);
    rchk("single idle", adcc_pkg::IDX_SC, 8'h00);
    $display("test continuous done");
    // Stop mode aborts, conversion resumes afterwards
    wr(adcc_pkg::IDX_SC, 8'h00);
    repeat (50) @(posedge aclk);
    stop_mode <= 1;
    repeat (400) @(posedge aclk);
    chk("stop power", 10'h001, {9'h000, converter_power_down});
    rchk("stop no result", adcc_pkg::IDX_SC, 8'h00);
    stop_mode <= 0;
    wait_flag();
    rchk("after stop", adcc_pkg::IDX_LOW, 8'h0F);
    // Channel decode and power off
    wr(adcc_pkg::IDX_SC, 8'h1F);
    repeat (600) @(posedge aclk);
    chk("power off", 10'h001, {9'h000, converter_power_down});
    rchk("off no result", adcc_pkg::IDX_SC, 8'h1F);
    wr(adcc_pkg::IDX_SC, 8'h1D);
    @(posedge aclk);
    chk("channel", {5'h00, adcc_pkg::CHAN_REFERENCE_HIGH_INPUT}, {5'h00, channel_select});
    chk("power on", 10'h000, {9'h000, converter_power_down});
    $display("test stop and channel done");
    stop_test();
  end
endmodule : tb
